// ===== include/pwr_pkg.sv
// Package: constants, modes and carriers for the power-down and wake-up control
package pwr_pkg;
   // Register offsets (registers of the plain register port)
   localparam logic [3:0] ADDR_MODE     = 4'h0;
   localparam logic [3:0] ADDR_CTRL     = 4'h1;
   localparam logic [3:0] ADDR_STATUS   = 4'h2;
   localparam logic [3:0] ADDR_WAKE_EN  = 4'h3;
   localparam logic [3:0] ADDR_STATE    = 4'h4;
   // Mode register fields
   localparam int MODE_IDLE_SEL  = 0;
   localparam int MODE_FAST_WAKE = 1;
   localparam int MODE_HIGH_CLK  = 2;
   localparam int MODE_XTAL_SEL  = 3;
   // Control register fields
   localparam int CTRL_FSYS_KEEP = 0;
   localparam int CTRL_WDT_EN    = 1;
   localparam int CTRL_LVD_EN    = 2;
   // Status register fields
   localparam int STAT_PDF       = 0;
   localparam int STAT_TO        = 1;
   localparam int STAT_HIGH_RDY  = 2;
   localparam int STAT_SLOW_RDY  = 3;
   // Reset values
   localparam logic [7:0] MODE_RST = 8'h04;
   localparam logic [7:0] CTRL_RST = 8'h02;
   // Start-up timer figures, in oscillator cycles
   localparam int XTAL_START_CYC = 128;
   localparam int SLOW_START_CYC = 2;

   typedef enum logic [2:0] {
      ST_RUN,
      ST_SLEEP_ALL_OFF,
      ST_SLEEP_SUBCLOCK_ON,
      ST_IDLE_SUBCLOCK_ONLY,
      ST_IDLE_ALL_CLOCKS_ON,
      ST_WAKE_START
   } pwr_state_t;

   typedef struct packed {
      logic sys_clk_en;
      logic tbase_clk_en;
      logic sub_clk_en;
      logic wdt_src_clk_en;
      logic high_osc_en;
      logic sys_from_low;
   } clk_ctl_t;

   typedef struct packed {
      logic full_reset;
      logic wdt_reset;
      logic irq_service;
      logic resume_next;
   } wake_act_t;
endpackage

// ===== rtl/startup_counter.sv
// Start-up cycle counter: counts enabled ticks up to a limit
`timescale 1ns/1ps
`default_nettype none
module startup_counter
   import pwr_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clear,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] limit,
   output logic                  done
);
   logic [WIDTH-1:0] cnt_r;
   logic [WIDTH-1:0] cnt_nxt;
   logic             done_r;
   logic             done_nxt;

   initial
   begin
      if (WIDTH < 2)
         $error("startup_counter width too small");
   end

   always_comb
   begin
      cnt_nxt  = cnt_r;
      done_nxt = done_r;
      if (clear)
      begin
         cnt_nxt  = '0;
         done_nxt = 1'b0;
      end
      else if (tick && !done_r)
      begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_nxt == limit)
            done_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cnt_r  <= '0;
         done_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign done = done_r;
endmodule
`default_nettype wire

// ===== rtl/power_down_wakeup_control.sv
// Power-down mode selection, wake-up handling and start-up sequencing
`timescale 1ns/1ps
`default_nettype none
module power_down_wakeup_control
   import pwr_pkg::*;
#(
   parameter int PORTA_W = 8,
   parameter int IRQ_W   = 4
)
(
   input  wire logic               ref_clk,
   input  wire logic               srst,
   input  wire logic [3:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   input  wire logic               halt_exec,
   input  wire logic               clr_wdt_exec,
   input  wire logic               ext_reset_n,
   input  wire logic [PORTA_W-1:0] porta_pin,
   input  wire logic [IRQ_W-1:0]   irq_flag,
   input  wire logic [IRQ_W-1:0]   irq_enable,
   input  wire logic               stack_full,
   input  wire logic               wdt_overflow,
   input  wire logic               xtal_tick,
   input  wire logic               slow_tick,
   output logic                    core_run,
   output logic                    wdt_clear,
   output logic                    wdt_run,
   output var clk_ctl_t            clk_ctl,
   output var wake_act_t           wake_act,
   output logic [IRQ_W-1:0]        irq_pending
);
   logic [7:0] mode_r, mode_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [PORTA_W-1:0] wake_en_r, wake_en_nxt;
   logic pdf_r, pdf_nxt;
   logic to_r, to_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   pwr_state_t state_r, state_nxt;
   pwr_state_t prior_r, prior_nxt;
   logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
   logic [IRQ_W-1:0] pend_r, pend_nxt;
   logic [PORTA_W-1:0] pa_s1_r, pa_s2_r, pa_s3_r;
   logic rst_s1_r, rst_s2_r;
   logic wdt_clear_r, wdt_clear_nxt;
   wake_act_t act_r, act_nxt;
   logic high_rdy_r, high_rdy_nxt;
   logic slow_phase_r, slow_phase_nxt;
   logic timer_clear;
   logic timer_tick;
   logic timer_done;
   logic [7:0] timer_limit;
   logic pin_wake, irq_wake, ext_wake, wdt_wake, any_wake;
   logic asleep;
   logic wdt_on, lvd_on;

   initial
   begin
      if (PORTA_W < 1 || PORTA_W > 8 || IRQ_W < 1 || IRQ_W > 8)
         $error("power_down_wakeup_control width out of range");
   end

   assign wdt_on = ctrl_r[CTRL_WDT_EN];
   assign lvd_on = ctrl_r[CTRL_LVD_EN];
   assign asleep = (state_r != ST_RUN) && (state_r != ST_WAKE_START);

   // Pin and external reset synchronisers; the pins pass through three stages, the external reset through two
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pa_s1_r  <= '1;
         pa_s2_r  <= '1;
         pa_s3_r  <= '1;
         rst_s1_r <= 1'b1;
         rst_s2_r <= 1'b1;
      end
      else
      begin
         pa_s1_r  <= porta_pin;
         pa_s2_r  <= pa_s1_r;
         pa_s3_r  <= pa_s2_r;
         rst_s1_r <= ext_reset_n;
         rst_s2_r <= rst_s1_r;
      end
   end

   assign pin_wake = |(pa_s3_r & ~pa_s2_r & wake_en_r);
   assign irq_wake = |(irq_flag & ~irq_mask_r);
   assign ext_wake = ~rst_s2_r;
   assign wdt_wake = wdt_overflow & wdt_on;
   assign any_wake = pin_wake | irq_wake | ext_wake | wdt_wake;

   // Shared timer: fast oscillator first, then slow one
   assign timer_limit = slow_phase_r ? 8'(SLOW_START_CYC) : 8'(XTAL_START_CYC);
   assign timer_tick  = slow_phase_r ? slow_tick : xtal_tick;
   assign timer_clear = (halt_exec && state_r == ST_RUN) || (timer_done && !slow_phase_r);

   startup_counter #(.WIDTH(8)) u_timer
   (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clear   (timer_clear),
      .tick    (timer_tick && !asleep && (!high_rdy_r || slow_phase_r)),
      .limit   (timer_limit),
      .done    (timer_done)
   );

   always_comb
   begin
      mode_nxt       = mode_r;
      ctrl_nxt       = ctrl_r;
      wake_en_nxt    = wake_en_r;
      pdf_nxt        = pdf_r;
      to_nxt         = to_r;
      state_nxt      = state_r;
      prior_nxt      = prior_r;
      irq_mask_nxt   = irq_mask_r;
      pend_nxt       = pend_r & irq_flag;
      wdt_clear_nxt  = 1'b0;
      act_nxt        = '0;
      high_rdy_nxt   = high_rdy_r;
      slow_phase_nxt = slow_phase_r;
      rdata_nxt      = 8'h00;
      // Registers are frozen while asleep, so writes land only in the run and wake-start states
      // state retained
      if (reg_wr && !asleep)
      begin
         case (reg_addr)
            ADDR_MODE:    mode_nxt    = reg_wdata;
            ADDR_CTRL:    ctrl_nxt    = reg_wdata;
            ADDR_WAKE_EN: wake_en_nxt = reg_wdata[PORTA_W-1:0];
            default:      ;
         endcase
      end
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_MODE:    rdata_nxt = mode_r;
            ADDR_CTRL:    rdata_nxt = ctrl_r;
            ADDR_STATUS:  rdata_nxt = {4'h0, ~slow_phase_r & high_rdy_r,
                                       high_rdy_r, to_r, pdf_r};
            ADDR_WAKE_EN: rdata_nxt = 8'(wake_en_r);
            ADDR_STATE:   rdata_nxt = 8'(state_r);
            default:      rdata_nxt = 8'h00;
         endcase
      end
      if (clr_wdt_exec && state_r == ST_RUN)
      begin
         pdf_nxt       = 1'b0;
         to_nxt        = 1'b0;
         wdt_clear_nxt = 1'b1;
      end
      // timer runs on after wake, slow after fast
      if (timer_done && !slow_phase_r && !high_rdy_r)
      begin
         high_rdy_nxt   = 1'b1;
         slow_phase_nxt = (prior_r == ST_SLEEP_ALL_OFF) && wdt_on;
      end
      else if (timer_done && slow_phase_r)
         slow_phase_nxt = 1'b0;
      case (state_r)
         ST_RUN:
         begin
            if (halt_exec)
            begin
               pdf_nxt       = 1'b1;
               to_nxt        = 1'b0;
               wdt_clear_nxt = 1'b1;
               irq_mask_nxt  = irq_flag;
               prior_nxt     = ST_RUN;
               if (mode_r[MODE_IDLE_SEL])
                  state_nxt = ctrl_r[CTRL_FSYS_KEEP] ? ST_IDLE_ALL_CLOCKS_ON
                                                     : ST_IDLE_SUBCLOCK_ONLY;
               else if (wdt_on || lvd_on)
                  state_nxt = ST_SLEEP_SUBCLOCK_ON;
               else
                  state_nxt = ST_SLEEP_ALL_OFF;
            end
         end
         ST_SLEEP_ALL_OFF, ST_SLEEP_SUBCLOCK_ON,
         ST_IDLE_SUBCLOCK_ONLY, ST_IDLE_ALL_CLOCKS_ON:
         begin
            prior_nxt = state_r;
            if (any_wake)
            begin
               if (ext_wake)
               begin
                  act_nxt.full_reset = 1'b1;
                  pdf_nxt            = 1'b0;
                  to_nxt             = 1'b0;
               end
               else if (wdt_wake)
               begin
                  act_nxt.wdt_reset = 1'b1;
                  to_nxt            = 1'b1;
               end
               else if (irq_wake)
               begin
                  if (|(irq_flag & ~irq_mask_r & irq_enable) && !stack_full)
                     act_nxt.irq_service = 1'b1;
                  else
                  begin
                     act_nxt.resume_next = 1'b1;
                     pend_nxt = pend_r | (irq_flag & ~irq_mask_r);
                  end
               end
               else
                  act_nxt.resume_next = 1'b1;
               if (state_r == ST_SLEEP_ALL_OFF ||
                   (state_r == ST_SLEEP_SUBCLOCK_ON && !mode_r[MODE_FAST_WAKE]))
               begin
                  high_rdy_nxt   = 1'b0;
                  slow_phase_nxt = 1'b0;
               end
               else if (state_r == ST_SLEEP_SUBCLOCK_ON || state_r == ST_IDLE_SUBCLOCK_ONLY)
                  high_rdy_nxt = !(mode_r[MODE_FAST_WAKE] && mode_r[MODE_XTAL_SEL]);
               state_nxt = ST_WAKE_START;
            end
         end
         ST_WAKE_START:
         begin
            // run when ready or on sub clock
            if (high_rdy_r || prior_r != ST_SLEEP_ALL_OFF)
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         mode_r       <= MODE_RST;
         ctrl_r       <= CTRL_RST;
         wake_en_r    <= '0;
         pdf_r        <= 1'b0;
         to_r         <= 1'b0;
         state_r      <= ST_RUN;
         prior_r      <= ST_RUN;
         irq_mask_r   <= '0;
         pend_r       <= '0;
         wdt_clear_r  <= 1'b0;
         act_r        <= '0;
         high_rdy_r   <= 1'b1;
         slow_phase_r <= 1'b0;
         rdata_r      <= 8'h00;
      end
      else
      begin
         mode_r       <= mode_nxt;
         ctrl_r       <= ctrl_nxt;
         wake_en_r    <= wake_en_nxt;
         pdf_r        <= pdf_nxt;
         to_r         <= to_nxt;
         state_r      <= state_nxt;
         prior_r      <= prior_nxt;
         irq_mask_r   <= irq_mask_nxt;
         pend_r       <= pend_nxt;
         wdt_clear_r  <= wdt_clear_nxt;
         act_r        <= act_nxt;
         high_rdy_r   <= high_rdy_nxt;
         slow_phase_r <= slow_phase_nxt;
         rdata_r      <= rdata_nxt;
      end
   end

   // Clock gating follows the current state
   always_comb
   begin
      clk_ctl = '0;
      clk_ctl.sub_clk_en     = wdt_on || lvd_on;
      clk_ctl.wdt_src_clk_en = wdt_on;
      clk_ctl.sys_from_low   = !mode_r[MODE_HIGH_CLK] || !high_rdy_r;
      clk_ctl.high_osc_en    = mode_r[MODE_HIGH_CLK];
      case (state_r)
         ST_RUN:
         begin
            clk_ctl.sys_clk_en   = 1'b1;
            clk_ctl.tbase_clk_en = 1'b1;
         end
         ST_SLEEP_ALL_OFF:
         begin
            clk_ctl.sub_clk_en     = 1'b0;
            clk_ctl.wdt_src_clk_en = 1'b0;
            clk_ctl.high_osc_en    = 1'b0;
         end
         ST_SLEEP_SUBCLOCK_ON: clk_ctl.high_osc_en = 1'b0;
         ST_IDLE_SUBCLOCK_ONLY:
         begin
            clk_ctl.tbase_clk_en = 1'b1;
            clk_ctl.sub_clk_en   = 1'b1;
            clk_ctl.high_osc_en  = 1'b0;
         end
         ST_IDLE_ALL_CLOCKS_ON:
         begin
            clk_ctl.sys_clk_en   = 1'b1;
            clk_ctl.tbase_clk_en = 1'b1;
            clk_ctl.sub_clk_en   = 1'b1;
         end
         ST_WAKE_START:
         begin
            clk_ctl.sys_clk_en   = 1'b1;
            clk_ctl.tbase_clk_en = 1'b1;
            clk_ctl.high_osc_en  = 1'b1;
         end
         default: clk_ctl.sys_clk_en = 1'b1;
      endcase
   end

   assign core_run    = (state_r == ST_RUN);
   assign wdt_clear   = wdt_clear_r;
   assign wdt_run     = wdt_on && state_r != ST_SLEEP_ALL_OFF;
   assign wake_act    = act_r;
   assign irq_pending = pend_r;
   assign reg_rdata   = rdata_r;
endmodule
`default_nettype wire

// ===== dv/pwr_ctl_asserts.sv
// Checker: port-level properties of the power-down and wake-up control
`timescale 1ns/1ps
`default_nettype none
module pwr_ctl_asserts
   import pwr_pkg::*;
#(
   parameter int PORTA_W = 8,
   parameter int IRQ_W   = 4
)
(
   input wire logic             ref_clk,
   input wire logic             srst,
   input wire logic             ext_reset_n,
   input wire logic             halt_exec,
   input wire logic [IRQ_W-1:0] irq_flag,
   input wire logic [IRQ_W-1:0] irq_enable,
   input wire logic             stack_full,
   input wire logic             wdt_overflow,
   input wire logic             core_run,
   input wire logic             wdt_clear,
   input wire clk_ctl_t         clk_ctl,
   input wire wake_act_t        wake_act,
   input wire logic [IRQ_W-1:0] irq_pending
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   a_halt_stops_core: assert property (core_run && halt_exec |=> !core_run)
      else $error("halt did not stop the core");
   a_entry_clears_wdt: assert property (core_run && halt_exec |=> wdt_clear)
      else $error("watchdog not cleared on entry");
   a_idle_all_clocks_on_keeps_all: assert property ($past(core_run && halt_exec) &&
      clk_ctl.sys_clk_en |-> clk_ctl.tbase_clk_en && clk_ctl.sub_clk_en)
      else $error("system clock kept without the others");
   a_sleep_stops_sys: assert property ($past(core_run && halt_exec) &&
      !clk_ctl.tbase_clk_en |-> !clk_ctl.sys_clk_en)
      else $error("system clock left running in sleep");
   a_all_off_stops: assert property ($past(core_run && halt_exec) &&
      !clk_ctl.sub_clk_en |-> !clk_ctl.tbase_clk_en && !clk_ctl.wdt_src_clk_en)
      else $error("clock left running in all-off sleep");
   a_wake_single: assert property ($onehot0(wake_act))
      else $error("more than one wake action");
   a_wdt_wake_cause: assert property (wake_act.wdt_reset |-> $past(wdt_overflow))
      else $error("watchdog reset without overflow");
   a_irq_wake_cause: assert property (wake_act.irq_service |->
      $past(|(irq_flag & irq_enable) && !stack_full))
      else $error("interrupt served without enabled request");
   a_pending_needs_flag: assert property ((irq_pending & ~$past(irq_flag)) == '0)
      else $error("pending interrupt without request flag");
   a_ext_reset_full: assert property ($fell(ext_reset_n) && !core_run
      |-> ##[1:5] wake_act.full_reset)
      else $error("external reset gave no full reset");
endmodule
bind power_down_wakeup_control pwr_ctl_asserts #(.PORTA_W(PORTA_W), .IRQ_W(IRQ_W)) chk_u (
   .ref_clk(ref_clk), .srst(srst), .ext_reset_n(ext_reset_n), .halt_exec(halt_exec),
   .irq_flag(irq_flag), .irq_enable(irq_enable), .stack_full(stack_full),
   .wdt_overflow(wdt_overflow), .core_run(core_run), .wdt_clear(wdt_clear),
   .clk_ctl(clk_ctl), .wake_act(wake_act), .irq_pending(irq_pending));
`default_nettype wire

// ===== dv/core_model.sv
// Partner model: processor core issuing power-down and serving interrupts
`timescale 1ns/1ps
`default_nettype none
module core_model
   import pwr_pkg::*;
#(
   parameter int IRQ_W = 4
)
(
   input  wire logic             ref_clk,
   input  wire wake_act_t        wake_act,
   output logic                  halt_exec,
   output logic                  clr_wdt_exec,
   output logic [IRQ_W-1:0]      irq_flag,
   output logic [IRQ_W-1:0]      irq_enable,
   output logic                  stack_full
);
   initial
   begin
      halt_exec    = 1'b0;
      clr_wdt_exec = 1'b0;
      irq_flag     = '0;
      irq_enable   = '0;
      stack_full   = 1'b0;
   end
   // Instructions are one-clock pulses, never overlapping
   task automatic op(input logic halt);
      @(posedge ref_clk);
      halt_exec    <= halt;
      clr_wdt_exec <= !halt;
      @(posedge ref_clk);
      halt_exec    <= 1'b0;
      clr_wdt_exec <= 1'b0;
   endtask
   task automatic irq(input logic [IRQ_W-1:0] f, input logic [IRQ_W-1:0] e, input logic full);
      @(posedge ref_clk);
      irq_flag   <= f;
      irq_enable <= e;
      stack_full <= full;
   endtask
   always @(posedge ref_clk)
      if (wake_act.irq_service)
         irq_flag <= irq_flag & ~irq_enable;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench: register, power-down and wake-up scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pwr_pkg::*;
   logic       ref_clk     = 1'b0;
   logic       srst;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic       ext_reset_n;
   logic [7:0] porta_pin;
   logic       wdt_overflow;
   logic       xtal_tick;
   logic       slow_tick;
   logic [1:0] tick_cnt    = 2'h0;
   logic [7:0] reg_rdata;
   logic       halt_exec, clr_wdt_exec, stack_full, core_run, wdt_clear, wdt_run;
   logic [3:0] irq_flag, irq_enable, irq_pending;
   clk_ctl_t   clk_ctl;
   wake_act_t  wake_act, last_act;
   int         error_cnt   = 0;
   int         checked     = 0;
   logic       c_idle  [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
   logic [2:0] c_ctrl  [5] = '{3'h2, 3'h4, 3'h2, 3'h3, 3'h0};
   logic [2:0] c_clk   [5] = '{3'h1, 3'h1, 3'h3, 3'h7, 3'h0};
   pwr_state_t c_state [5] = '{ST_SLEEP_SUBCLOCK_ON, ST_SLEEP_SUBCLOCK_ON,
      ST_IDLE_SUBCLOCK_ONLY, ST_IDLE_ALL_CLOCKS_ON, ST_SLEEP_ALL_OFF};

   power_down_wakeup_control #(.PORTA_W(8), .IRQ_W(4)) dut_u (.ref_clk(ref_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec),
      .ext_reset_n(ext_reset_n), .porta_pin(porta_pin), .irq_flag(irq_flag),
      .irq_enable(irq_enable), .stack_full(stack_full), .wdt_overflow(wdt_overflow),
      .xtal_tick(xtal_tick), .slow_tick(slow_tick), .core_run(core_run),
      .wdt_clear(wdt_clear), .wdt_run(wdt_run), .clk_ctl(clk_ctl), .wake_act(wake_act),
      .irq_pending(irq_pending));
   core_model #(.IRQ_W(4)) core_u (.ref_clk(ref_clk), .wake_act(wake_act),
      .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .irq_flag(irq_flag),
      .irq_enable(irq_enable), .stack_full(stack_full));

   always #4 ref_clk = ~ref_clk;
   // Crystal ticks every second clock so start-up counts stay visible
   always @(posedge ref_clk)
   begin
      tick_cnt  <= tick_cnt + 2'h1;
      xtal_tick <= tick_cnt[0];
      slow_tick <= &tick_cnt;
      if (wake_act != '0)
         last_act <= wake_act;
   end

   task automatic chk(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                     input string what);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1 chk((reg_rdata & m) === e, what);
   endtask
   task automatic wait_run(input int n, input string what);
      for (int i = 0; i < n && core_run !== 1'b1; i++)
         @(posedge ref_clk) #1;
      chk(core_run === 1'b1, what);
   endtask
   task automatic pin_wake(input int n, input string what);
      last_act = '0;
      @(posedge ref_clk);
      porta_pin <= 8'hFE;
      wait_run(n, what);
      @(posedge ref_clk);
      porta_pin <= 8'hFF;
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      srst         = 1'b1;
      reg_addr     = 4'h0;
      reg_wdata    = 8'h00;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      ext_reset_n  = 1'b1;
      porta_pin    = 8'hFF;
      wdt_overflow = 1'b0;
      xtal_tick    = 1'b0;
      slow_tick    = 1'b0;
      last_act     = '0;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      rd(ADDR_MODE, 8'hFF, MODE_RST, "mode reset");
      rd(ADDR_CTRL, 8'hFF, CTRL_RST, "ctrl reset");
      rd(ADDR_STATUS, 8'h07, 8'h04, "status reset");
      rd(4'hF, 8'hFF, 8'h00, "unmapped read");
      wr(ADDR_WAKE_EN, 8'h01);
      for (int k = 0; k < 5; k++)
      begin
         wr(ADDR_MODE, MODE_RST | {7'h0, c_idle[k]});
         wr(ADDR_CTRL, {5'h0, c_ctrl[k]});
         core_u.op(1'b1);
         #1 chk(core_run === 1'b0, "core still running");
         chk(clk_ctl[5:3] === c_clk[k], "clocks");
         chk(wdt_run === c_ctrl[k][1], "watchdog run");
         rd(ADDR_STATE, 8'hFF, {5'h0, c_state[k]}, "state code");
         rd(ADDR_STATUS, 8'h03, 8'h01, "flags after halt");
         wr(ADDR_WAKE_EN, 8'h00);
         pin_wake(400, "pin wake");
         chk(last_act.resume_next === 1'b1, "pin wake action");
         rd(ADDR_WAKE_EN, 8'hFF, 8'h01, "write in sleep taken");
         rd(ADDR_MODE, 8'hFF, MODE_RST | {7'h0, c_idle[k]}, "mode lost");
      end
      core_u.op(1'b0);
      rd(ADDR_STATUS, 8'h03, 8'h00, "flags after clear");
      wr(ADDR_MODE, 8'h05);
      wr(ADDR_CTRL, 8'h03);
      core_u.op(1'b1);
      last_act = '0;
      @(posedge ref_clk);
      wdt_overflow <= 1'b1;
      @(posedge ref_clk);
      wdt_overflow <= 1'b0;
      wait_run(20, "watchdog wake");
      chk(last_act.wdt_reset === 1'b1, "watchdog reset action");
      rd(ADDR_STATUS, 8'h03, 8'h03, "timeout flag");
      core_u.irq(4'h2, 4'h2, 1'b0);
      core_u.op(1'b1);
      repeat (10) @(posedge ref_clk);
      #1 chk(core_run === 1'b0, "early request woke");
      last_act = '0;
      // Stale request stays masked; a fresh one on another line wakes
      core_u.irq(4'h2, 4'h6, 1'b0);
      core_u.irq(4'h6, 4'h6, 1'b0);
      wait_run(20, "irq wake");
      chk(last_act.irq_service === 1'b1, "irq not served");
      for (int k = 0; k < 2; k++)
      begin
         core_u.irq(4'h0, 4'h0, 1'b0);
         core_u.op(1'b1);
         last_act = '0;
         core_u.irq(4'h1, {3'h0, k[0]}, k[0]);
         wait_run(20, "irq resume");
         chk(last_act.resume_next === 1'b1 && irq_pending === 4'h1, "irq pending");
      end
      core_u.irq(4'h0, 4'h0, 1'b0);
      wr(ADDR_MODE, 8'h0E);
      wr(ADDR_CTRL, 8'h02);
      core_u.op(1'b1);
      pin_wake(20, "fast wake");
      chk(clk_ctl.sys_from_low === 1'b1, "not on sub clock");
      rd(ADDR_STATUS, 8'h04, 8'h00, "high clock ready early");
      // Margin covers the counter's done flag and the ready register
      repeat (2 * XTAL_START_CYC + 4) @(posedge ref_clk);
      rd(ADDR_STATUS, 8'h04, 8'h04, "high clock not ready");
      chk(clk_ctl.sys_from_low === 1'b0, "not back on crystal");
      wr(ADDR_MODE, MODE_RST);
      core_u.op(1'b1);
      last_act = '0;
      @(posedge ref_clk);
      ext_reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ext_reset_n <= 1'b1;
      #1 chk(last_act.full_reset === 1'b1, "external reset wake");
      report_and_stop();
   end

   initial
   begin
      #100000;
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      report_and_stop();
   end
endmodule
`default_nettype wire
